// file: shared/arc_consts.svh
// constants of the result computation and threshold unit
`ifndef ARC_CONSTS_SVH
`define ARC_CONSTS_SVH

// register byte offsets
`define ARC_OFF_CTRL    8'h00
`define ARC_OFF_CALC    8'h04
`define ARC_OFF_RPT     8'h08
`define ARC_OFF_UTH     8'h0c
`define ARC_OFF_LTH     8'h10
`define ARC_OFF_STAT    8'h14
`define ARC_OFF_RES     8'h18
`define ARC_OFF_PREV    8'h1c
`define ARC_OFF_ACC     8'h20
`define ARC_OFF_FLT     8'h24
`define ARC_OFF_ERR     8'h28
`define ARC_OFF_SETP    8'h2c
`define ARC_OFF_ISTAT   8'h30
`define ARC_OFF_IMASK   8'h34

// control and calc register fields
`define ARC_CTRL_MODE   2:0
`define ARC_CTRL_FREE_RUN_ENABLE   3
`define ARC_CTRL_SOI    4
`define ARC_CTRL_DSEN   5
`define ARC_CTRL_PSIS   6
`define ARC_CTRL_GO     7
`define ARC_CTRL_CRS    10:8
`define ARC_CALC_CALC   2:0
`define ARC_CALC_TMD    6:4

// interrupt status bits
`define ARC_IRQ_THR     0
`define ARC_IRQ_DONE    1
`define ARC_IRQ_W       2

// computation modes
`define ARC_MODE_BASIC  3'h0
`define ARC_MODE_ACCUM  3'h1
`define ARC_MODE_AVG    3'h2
`define ARC_MODE_BURST  3'h3
`define ARC_MODE_LPF    3'h4

// error methods
`define ARC_CALC_DSNG   3'h0
`define ARC_CALC_CVD    3'h1
`define ARC_CALC_RSET   3'h2
`define ARC_CALC_RFLT   3'h3
`define ARC_CALC_DFLT   3'h4
`define ARC_CALC_FSET   3'h5

// threshold tests
`define ARC_TMD_NEVER   3'h0
`define ARC_TMD_LT_L    3'h1
`define ARC_TMD_GE_L    3'h2
`define ARC_TMD_IN      3'h3
`define ARC_TMD_OUT     3'h4
`define ARC_TMD_LE_U    3'h5
`define ARC_TMD_GT_U    3'h6
`define ARC_TMD_ALWAYS  3'h7

// reset values
`define ARC_RPT_RST     8'h01

`endif

// file: shared/arc_pkg.sv
// types of the result computation and threshold unit
package arc_pkg;
    typedef logic [2:0] arc_sel_type;
    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_EVAL} arc_state_type;
endpackage : arc_pkg

// file: logic/arc_accum.sv
// accumulator and filter arithmetic for one new sample
`timescale 1ns/1ps
`default_nettype none
`include "arc_consts.svh"
module arc_accum
    import arc_pkg::*;
#(
    parameter int DW = 12,
    parameter int AW = 18
) (
    input  wire logic [2:0]    mode,      // computation mode
    input  wire logic [2:0]    crs,       // filter shift
    input  wire logic [AW-1:0] acc,       // current accumulator
    input  wire logic [DW-1:0] sample,    // new sample
    output logic      [AW-1:0] acc_nxt,   // next accumulator
    output logic               ovf,       // accumulator carried out
    output logic      [15:0]   flt_nxt    // filtered or average value
);
    wire logic [AW:0]   sum_w  = {1'b0, acc} + {{(AW+1-DW){1'b0}}, sample};
    wire logic [AW-1:0] decay_w = acc - (acc >> crs);
    wire logic [AW:0]   lpf_w  = {1'b0, decay_w} + {{(AW+1-DW){1'b0}}, sample};
    wire logic [AW:0]   pick_w = (mode == `ARC_MODE_LPF) ? lpf_w : sum_w;
    wire logic [AW:0]   shr_w  = pick_w >> crs;

    always_comb begin
        acc_nxt = pick_w[AW-1:0];
        ovf     = pick_w[AW];
        flt_nxt = shr_w[15:0];
        if (mode == `ARC_MODE_BASIC) begin
            acc_nxt = {{(AW-DW){1'b0}}, sample};
            ovf     = 1'b0;
            flt_nxt = {{(16-DW){1'b0}}, sample};
        end else if (mode == `ARC_MODE_ACCUM) begin
            flt_nxt = {{(16-DW){1'b0}}, sample};
        end
    end
endmodule : arc_accum
`default_nettype wire

// file: logic/arc_thresh.sv
// deviation calculation and eight-way signed threshold test
`timescale 1ns/1ps
`default_nettype none
`include "arc_consts.svh"
module arc_thresh
    import arc_pkg::*;
(
    input  wire logic [2:0]         calc,   // error method select
    input  wire logic [2:0]         tmd,    // threshold mode
    input  wire logic signed [15:0] res,    // new result
    input  wire logic signed [15:0] prev,   // prior sample
    input  wire logic signed [15:0] flt,    // filtered value
    input  wire logic signed [15:0] fprev,  // filtered value before this one
    input  wire logic signed [15:0] setp,   // setpoint
    input  wire logic signed [15:0] upper_threshold,    // upper threshold
    input  wire logic signed [15:0] lower_threshold,    // lower threshold
    input  wire logic               aov,    // accumulator overflow
    output logic signed      [15:0] err,    // deviation value
    output logic                    above,  // err above upper
    output logic                    below,  // err below lower
    output logic                    hit     // interrupt condition
);
    logic tst;

    always_comb begin
        case (calc)
            `ARC_CALC_DSNG: err = res - prev;
            `ARC_CALC_CVD:  err = prev - res;
            `ARC_CALC_RSET: err = res - setp;
            `ARC_CALC_RFLT: err = res - flt;
            `ARC_CALC_DFLT: err = flt - fprev;
            `ARC_CALC_FSET: err = flt - setp;
            default:        err = 16'sh0000;
        endcase
    end

    // all compares are signed
    assign above = err > upper_threshold;
    assign below = err < lower_threshold;

    always_comb begin
        case (tmd)
            `ARC_TMD_NEVER:  tst = 1'b0;
            `ARC_TMD_LT_L:   tst = below;
            `ARC_TMD_GE_L:   tst = !below;
            `ARC_TMD_IN:     tst = !below && !above;
            `ARC_TMD_OUT:    tst = below || above;
            `ARC_TMD_LE_U:   tst = !above;
            `ARC_TMD_GT_U:   tst = above;
            default:         tst = 1'b1;
        endcase
    end

    assign hit = tst || aov;
endmodule : arc_thresh
`default_nettype wire

// file: logic/arc_top.sv
// converter result computation, threshold test and conversion sequencing
//
// What this block does
// - burst average keeps re-triggering until the count reaches the repeat setting.
// - low-pass mode accumulates until the count reaches repeat, filters, then tests.
// - the filter shift setting sets the low-pass cut-off.
// - result and prior move with every evaluated sample except the first of a pair; filter, error and flags only at the end of each computation.
// - a three-bit select picks one of six deviation calculations.
// - the deviation is compared with both thresholds to update the two flags.
// - a three-bit threshold mode picks one of eight tests.
// - a satisfied test sets the threshold interrupt flag.
// - free-running mode starts the next conversion itself and keeps start set.
// - with stop-on-interrupt, a threshold hit clears start and stops conversions.
// - double sampling needs two separately started conversions unless free-running.
// - the first of two only sets the phase bit, stores the sample and updates the accumulator and its overflow flag.
// - the second moves the first to prior, stores the result, then tests.
`timescale 1ns/1ps
`default_nettype none
`include "arc_consts.svh"
module arc_top
    import arc_pkg::*;
#(
    parameter int DW = 12,
    parameter int AW = 18
) (
    input  wire logic          sys_clk,    // 20 MHz clock
    input  wire logic          rst_b,      // async reset, active low
    input  wire logic [7:0]    reg_addr,   // register byte address
    input  wire logic [31:0]   reg_wdata,  // write data
    input  wire logic          reg_wr,     // write strobe
    input  wire logic          reg_rd,     // read strobe
    output logic      [31:0]   reg_rdata,  // read data, cycle after strobe
    input  wire logic          trig_in,    // trigger pulse, sets start
    output logic               conv_start, // request a conversion
    input  wire logic          conv_done,  // conversion finished pulse
    input  wire logic [DW-1:0] conv_data,  // conversion value
    output logic               irq         // level interrupt
);
    // ********************************
    // registers
    // ********************************
    arc_state_type   state_q;
    logic [2:0]      mode_q, crs_q, calc_q, tmd_q;
    logic            free_run_enable_q, soi_q, dsen_q, psis_q, go_q;
    logic [7:0]      rpt_q, cnt_q;
    logic [15:0]     uth_q, lth_q, setp_q;
    logic [15:0]     res_q, prev_q, flt_q, err_q, first_q;
    logic [AW-1:0]   acc_q;
    logic [DW-1:0]   samp_q;
    logic            uthr_q;
    logic            lthr_q;
    logic            math_q;
    logic            aov_q;
    logic [`ARC_IRQ_W-1:0] ist_q, imsk_q;
    logic [31:0]     rdata_q;

    // ********************************
    // bus decode
    // ********************************
    wire logic wr_ctrl  = reg_wr && (reg_addr == `ARC_OFF_CTRL);
    wire logic wr_calc  = reg_wr && (reg_addr == `ARC_OFF_CALC);
    wire logic wr_rpt   = reg_wr && (reg_addr == `ARC_OFF_RPT);
    wire logic wr_uth   = reg_wr && (reg_addr == `ARC_OFF_UTH);
    wire logic wr_lth   = reg_wr && (reg_addr == `ARC_OFF_LTH);
    wire logic wr_setp  = reg_wr && (reg_addr == `ARC_OFF_SETP);
    wire logic wr_ist   = reg_wr && (reg_addr == `ARC_OFF_ISTAT);
    wire logic wr_imsk  = reg_wr && (reg_addr == `ARC_OFF_IMASK);

    // ********************************
    // computation datapath
    // ********************************
    wire logic          eval     = (state_q == ST_EVAL);
    wire logic          ds_first = dsen_q && !math_q;
    wire logic [7:0]    cnt_inc  = cnt_q + 8'h01;
    wire logic          cnt_done = cnt_inc >= rpt_q;
    wire logic          avg_like = (mode_q == `ARC_MODE_AVG) || (mode_q == `ARC_MODE_BURST);
    wire logic          batch    = avg_like || (mode_q == `ARC_MODE_LPF);
    // averaging and filter modes only test once the batch is complete
    wire logic          compute  = eval && !ds_first && (!batch || cnt_done);
    wire logic          first_ev = eval && ds_first;
    wire logic [AW-1:0] acc_nxt;
    wire logic          ovf;
    wire logic [15:0]   flt_nxt;
    wire logic [15:0]   err_nxt;
    wire logic          above;
    wire logic          below;
    wire logic          hit;

    arc_accum #(
        .DW (DW),
        .AW (AW)
    ) u_accum (
        .mode    (mode_q),
        .crs     (crs_q),
        .acc     (acc_q),
        .sample  (samp_q),
        .acc_nxt (acc_nxt),
        .ovf     (ovf),
        .flt_nxt (flt_nxt)
    );

    wire logic [15:0] res_n  = {{(16-DW){1'b0}}, samp_q};
    // the prior value is the last result, the first of a pair, or the filtered value on request
    wire logic [15:0] prev_n = psis_q ? flt_q : (dsen_q ? first_q : res_q);
    wire logic [15:0] flt_n  = compute ? flt_nxt : flt_q;
    // overflow stays set until an average batch completes, so it keeps forcing hits
    wire logic        aov_n  = aov_q || ovf;

    arc_thresh u_thresh (
        .calc  (calc_q),
        .tmd   (tmd_q),
        .res   (res_n),
        .prev  (prev_n),
        .flt   (flt_n),
        .fprev (flt_q),
        .setp  (setp_q),
        .upper_threshold   (uth_q),
        .lower_threshold   (lth_q),
        .aov   (aov_n),
        .err   (err_nxt),
        .above (above),
        .below (below),
        .hit   (hit)
    );

    wire logic thr_ev  = compute && hit;
    wire logic stop_ev = thr_ev && soi_q;
    // burst mode re-triggers on its own within a batch
    wire logic burst_more = (mode_q == `ARC_MODE_BURST) && !cnt_done && !ds_first;
    wire logic keep_go = !stop_ev && (free_run_enable_q || burst_more);
    // a start written or triggered in the evaluate cycle beats the hardware clear
    wire logic sw_go   = (wr_ctrl && reg_wdata[`ARC_CTRL_GO]) || trig_in;
    wire logic sw_stop = wr_ctrl && !reg_wdata[`ARC_CTRL_GO];
    // each conversion of a pair needs its own start unless free-running
    wire logic go_d = sw_go ? 1'b1 :
                      sw_stop ? 1'b0 :
                      (eval && !keep_go) ? 1'b0 : go_q;
    wire logic [`ARC_IRQ_W-1:0] ev_set = {compute, thr_ev};
    wire logic [`ARC_IRQ_W-1:0] ist_d  =
        ev_set | (ist_q & ~(wr_ist ? reg_wdata[`ARC_IRQ_W-1:0] : {`ARC_IRQ_W{1'b0}}));

    // request follows go while the sequencer is idle and drops as the sequencer leaves idle
    assign conv_start = go_q && (state_q == ST_IDLE);
    assign irq        = |(ist_q & imsk_q);
    assign reg_rdata  = rdata_q;

    // ********************************
    // conversion sequencer
    // ********************************
    // a done pulse outside the converting state is dropped
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            samp_q  <= '0;
        end else begin
            case (state_q)
                ST_IDLE: if (conv_start) state_q <= ST_CONV;
                ST_CONV: if (conv_done) begin
                    state_q <= ST_EVAL;
                    samp_q  <= conv_data;
                end
                ST_EVAL: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ********************************
    // software settings
    // ********************************
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            {mode_q, free_run_enable_q, soi_q, dsen_q, psis_q, crs_q} <= '0;
            {calc_q, tmd_q} <= '0;
            rpt_q  <= `ARC_RPT_RST;
            uth_q  <= '0;
            lth_q  <= '0;
            setp_q <= '0;
            imsk_q <= '0;
            go_q   <= 1'b0;
        end else begin
            go_q <= go_d;
            if (wr_ctrl) begin
                mode_q <= reg_wdata[`ARC_CTRL_MODE];
                free_run_enable_q <= reg_wdata[`ARC_CTRL_FREE_RUN_ENABLE];
                soi_q  <= reg_wdata[`ARC_CTRL_SOI];
                dsen_q <= reg_wdata[`ARC_CTRL_DSEN];
                psis_q <= reg_wdata[`ARC_CTRL_PSIS];
                crs_q  <= reg_wdata[`ARC_CTRL_CRS];
            end
            if (wr_calc) begin
                calc_q <= reg_wdata[`ARC_CALC_CALC];
                tmd_q  <= reg_wdata[`ARC_CALC_TMD];
            end
            if (wr_rpt) rpt_q <= reg_wdata[7:0];
            if (wr_uth) uth_q <= reg_wdata[15:0];
            if (wr_lth) lth_q <= reg_wdata[15:0];
            if (wr_setp) setp_q <= reg_wdata[15:0];
            if (wr_imsk) imsk_q <= reg_wdata[`ARC_IRQ_W-1:0];
        end
    end

    // ********************************
    // accumulation and pairing
    // ********************************
    // the count also runs in single-sample modes and only restarts at a batch end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_q   <= '0;
            cnt_q   <= '0;
            aov_q   <= 1'b0;
            math_q  <= 1'b0;
            first_q <= '0;
        end else if (first_ev) begin
            math_q  <= 1'b1;
            first_q <= res_n;
            acc_q   <= acc_nxt;
            aov_q   <= aov_n;
        end else if (eval) begin
            math_q <= 1'b0;
            // a finished average starts the next batch from empty
            if (compute && avg_like) begin
                acc_q <= '0;
                cnt_q <= '0;
                aov_q <= 1'b0;
            end else begin
                acc_q <= acc_nxt;
                cnt_q <= (compute && batch) ? 8'h00 : cnt_inc;
                aov_q <= aov_n;
            end
        end
    end

    // ********************************
    // results and flags
    // ********************************
    // results only move in the evaluate cycle; filter, error and flags hold between computations
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            res_q  <= '0;
            prev_q <= '0;
            flt_q  <= '0;
            err_q  <= '0;
            uthr_q <= 1'b0;
            lthr_q <= 1'b0;
        end else if (eval && !ds_first) begin
            res_q  <= res_n;
            prev_q <= prev_n;
            if (compute) begin
                flt_q  <= flt_nxt;
                err_q  <= err_nxt;
                uthr_q <= above;
                lthr_q <= below;
            end
        end
    end

    // ********************************
    // interrupts and read port
    // ********************************
    // hardware set beats a same-cycle write-one clear
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ist_q <= '0;
        end else begin
            ist_q <= ist_d;
        end
    end

    // read-only results share one decode with the settings
    logic [31:0] rd_mux;
    always_comb begin
        case (reg_addr)
            `ARC_OFF_CTRL:  rd_mux = {21'h0, crs_q, go_q, psis_q, dsen_q,
                                      soi_q, free_run_enable_q, mode_q};
            `ARC_OFF_CALC:  rd_mux = {25'h0, tmd_q, 1'b0, calc_q};
            `ARC_OFF_RPT:   rd_mux = {24'h0, rpt_q};
            `ARC_OFF_UTH:   rd_mux = {16'h0, uth_q};
            `ARC_OFF_LTH:   rd_mux = {16'h0, lth_q};
            `ARC_OFF_STAT:  rd_mux = {16'h0, cnt_q, 4'h0, aov_q, math_q,
                                      lthr_q, uthr_q};
            `ARC_OFF_RES:   rd_mux = {16'h0, res_q};
            `ARC_OFF_PREV:  rd_mux = {16'h0, prev_q};
            `ARC_OFF_ACC:   rd_mux = {{(32-AW){1'b0}}, acc_q};
            `ARC_OFF_FLT:   rd_mux = {16'h0, flt_q};
            `ARC_OFF_ERR:   rd_mux = {16'h0, err_q};
            `ARC_OFF_SETP:  rd_mux = {16'h0, setp_q};
            `ARC_OFF_ISTAT: rd_mux = {30'h0, ist_q};
            `ARC_OFF_IMASK: rd_mux = {30'h0, imsk_q};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    // unmapped addresses read zero; data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end
endmodule : arc_top
`default_nettype wire

// file: bench/arc_props.sv
// port checker of the result computation and threshold unit
`timescale 1ns/1ps
`default_nettype none
`include "arc_consts.svh"
module arc_props #(
    parameter int DW = 12,
    parameter int AW = 18
) (
    input wire logic          sys_clk,    // clock
    input wire logic          rst_b,      // async reset, active low
    input wire logic [7:0]    reg_addr,   // register address
    input wire logic [31:0]   reg_wdata,  // write data
    input wire logic          reg_wr,     // write strobe
    input wire logic          reg_rd,     // read strobe
    input wire logic [31:0]   reg_rdata,  // read data
    input wire logic          trig_in,    // trigger pulse
    input wire logic          conv_start, // conversion request
    input wire logic          conv_done,  // conversion end pulse
    input wire logic [DW-1:0] conv_data,  // sample value
    input wire logic          irq         // interrupt level
);
    // ****************************************
    // shadow state seen from the ports
    // ****************************************
    logic       pend_q;
    logic       act_q;
    logic       trg_q;
    logic       rd_q;
    logic       done1_q;
    logic       done2_q;
    logic [7:0] rpt_q;
    logic [1:0] mask_q;

    // the shadows only follow the ports and bus writes, so they stay valid without seeing the body
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            {pend_q, act_q, trg_q, rd_q, done1_q, done2_q} <= 6'h0;
            rpt_q  <= `ARC_RPT_RST;
            mask_q <= 2'h0;
        end else begin
            pend_q  <= conv_start || (pend_q && !conv_done);
            act_q   <= reg_wr;
            trg_q   <= trig_in;
            rd_q    <= reg_rd;
            done1_q <= conv_done;
            done2_q <= done1_q;
            if (reg_wr && reg_addr == `ARC_OFF_RPT) rpt_q <= reg_wdata[7:0];
            if (reg_wr && reg_addr == `ARC_OFF_IMASK) mask_q <= reg_wdata[1:0];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    chk_start_gap: assert property (conv_start |=> !conv_start [*2])
        else $error("conversion request repeated too soon");
    chk_start_pend: assert property (conv_start |-> !pend_q)
        else $error("conversion request before the previous one ended");
    chk_start_cause: assert property ($rose(conv_start) |-> act_q || trg_q || done2_q)
        else $error("conversion request without write, trigger or finished conversion");
    chk_irq_cause: assert property ($changed(irq) |-> act_q || done2_q)
        else $error("interrupt moved without write or computation");
    chk_irq_masked: assert property (mask_q == 2'h0 |-> !irq)
        else $error("interrupt high while fully masked");
    chk_rdata_idle: assert property (!rd_q |-> reg_rdata == 32'h0)
        else $error("read data not zero outside the read cycle");
    chk_hole_zero: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_rpt_read: assert property (reg_rd && reg_addr == `ARC_OFF_RPT |=> reg_rdata == {24'h0, rpt_q})
        else $error("repeat setting read back wrong");
    chk_mask_read: assert property (reg_rd && reg_addr == `ARC_OFF_IMASK |=> reg_rdata == {30'h0, mask_q})
        else $error("interrupt mask read back wrong");

    cov_start: cover property (conv_start);
    cov_irq: cover property ($rose(irq));
    cov_free: cover property (done2_q && $rose(conv_start));
endmodule : arc_props

bind arc_top arc_props #(.DW(DW), .AW(AW)) u_props (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in),
    .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data), .irq(irq));
`default_nettype wire

// file: bench/arc_top_bench.sv
// self-checking bench of the result computation and threshold unit
`timescale 1ns/1ps
`default_nettype none
`include "arc_consts.svh"
module arc_top_bench;
    localparam logic [31:0] ALL = 32'hffffffff;
    logic        sys_clk;
    logic        rst_b;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        trig_in;
    logic        conv_start;
    logic        conv_done;
    logic [11:0] conv_data;
    logic        irq;
    int          bad_count = 0;
    int          compares = 0;
    int          t;
    int          k;
    logic [7:0]  hit_tab [3];
    logic [11:0] smp_tab [3];
    logic [1:0]  stat_tab [3];

    arc_top uut (
        .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in),
        .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data), .irq(irq));

    // ****************************************
    // bus and converter tasks
    // ****************************************
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        check($sformatf("register %h", a), reg_rdata & m, e);
    endtask : rd

    // waits for the request, then answers one cycle after it was taken
    task automatic conv(input logic [11:0] d);
        int i;
        for (i = 0; i < 40 && conv_start !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (i == 40) begin
            bad_count++;
            $display("FAIL conv_start expected 1 seen 0");
            print_verdict();
        end
        @(posedge sys_clk);
        conv_done <= 1'b1;
        conv_data <= d;
        @(posedge sys_clk);
        conv_done <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask : conv

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        {rst_b, reg_wr, reg_rd, trig_in, conv_done} = 5'h0;
        reg_addr  = 8'h0;
        reg_wdata = 32'h0;
        conv_data = 12'h0;
        hit_tab   = '{8'hd4, 8'hb2, 8'hac};
        smp_tab   = '{12'h078, 12'h050, 12'h064};
        stat_tab  = '{2'h1, 2'h2, 2'h0};
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        #1;
        rd(`ARC_OFF_CTRL, ALL, 32'h0);
        rd(`ARC_OFF_RPT, ALL, 32'h1);
        rd(8'h40, ALL, 32'h0);
        $display("test reset values done");
        // burst of four must run on its own after a single start
        wr(`ARC_OFF_RPT, 32'h4);
        wr(`ARC_OFF_CALC, 32'h5);
        wr(`ARC_OFF_CTRL, 32'h283);
        for (k = 1; k <= 4; k++) conv(12'(k * 10));
        rd(`ARC_OFF_FLT, ALL, 32'h19);
        rd(`ARC_OFF_ERR, 32'hffff, 32'h19);
        rd(`ARC_OFF_CTRL, 32'h80, 32'h0);
        $display("test burst done");
        // plain average needs a fresh start for every sample
        for (k = 1; k <= 4; k++) begin
            wr(`ARC_OFF_CTRL, 32'h182);
            conv(12'(k * 10));
        end
        rd(`ARC_OFF_FLT, ALL, 32'h32);
        rd(`ARC_OFF_ACC, ALL, 32'h0);
        rd(`ARC_OFF_CTRL, 32'h80, 32'h0);
        $display("test average done");
        wr(`ARC_OFF_RPT, 32'h2);
        wr(`ARC_OFF_ISTAT, 32'h3);
        wr(`ARC_OFF_CTRL, 32'h184);
        conv(12'h064);
        rd(`ARC_OFF_ISTAT, ALL, 32'h0);
        trig_in <= 1'b1;
        @(posedge sys_clk);
        trig_in <= 1'b0;
        // let the start set by the trigger settle before looking for the request
        #1;
        conv(12'h064);
        rd(`ARC_OFF_ACC, ALL, 32'h96);
        rd(`ARC_OFF_FLT, ALL, 32'h4b);
        rd(`ARC_OFF_ISTAT, ALL, 32'h2);
        $display("test low-pass done");
        for (t = 0; t < 2; t++) begin
            wr(`ARC_OFF_CALC, {28'h0, 4'(t)});
            wr(`ARC_OFF_CTRL, 32'h80);
            conv(12'h12c);
            wr(`ARC_OFF_CTRL, 32'h80);
            conv(12'h0fa);
            rd(`ARC_OFF_ERR, 32'hffff, t == 0 ? 32'hffce : 32'h32);
        end
        rd(`ARC_OFF_RES, ALL, 32'hfa);
        rd(`ARC_OFF_PREV, ALL, 32'h12c);
        $display("test error methods done");
        wr(`ARC_OFF_SETP, 32'h64);
        wr(`ARC_OFF_UTH, 32'ha);
        wr(`ARC_OFF_LTH, 32'hfff6);
        wr(`ARC_OFF_IMASK, 32'h1);
        for (t = 0; t < 8; t++) begin
            for (k = 0; k < 3; k++) begin
                wr(`ARC_OFF_CALC, {25'h0, t[2:0], 4'h2});
                wr(`ARC_OFF_ISTAT, 32'h3);
                wr(`ARC_OFF_CTRL, 32'h80);
                conv(smp_tab[k]);
                rd(`ARC_OFF_ISTAT, ALL, {30'h0, 1'b1, hit_tab[k][t]});
                rd(`ARC_OFF_STAT, 32'h3, {30'h0, stat_tab[k]});
                check("irq", {31'h0, irq}, {31'h0, hit_tab[k][t]});
            end
        end
        wr(`ARC_OFF_IMASK, 32'h0);
        check("irq", {31'h0, irq}, 32'h0);
        wr(`ARC_OFF_ISTAT, 32'h1);
        rd(`ARC_OFF_ISTAT, ALL, 32'h2);
        $display("test threshold table done");
        wr(`ARC_OFF_CALC, 32'h62);
        wr(`ARC_OFF_CTRL, 32'h98);
        conv(12'h032);
        conv(12'h0c8);
        rd(`ARC_OFF_CTRL, ALL, 32'h18);
        $display("test free run done");
        wr(`ARC_OFF_CALC, 32'h70);
        wr(`ARC_OFF_ISTAT, 32'h3);
        wr(`ARC_OFF_CTRL, 32'ha0);
        conv(12'h190);
        rd(`ARC_OFF_ISTAT, ALL, 32'h0);
        rd(`ARC_OFF_STAT, 32'h4, 32'h4);
        rd(`ARC_OFF_RES, ALL, 32'hc8);
        rd(`ARC_OFF_CTRL, 32'h80, 32'h0);
        wr(`ARC_OFF_CTRL, 32'ha0);
        conv(12'h096);
        rd(`ARC_OFF_RES, ALL, 32'h96);
        rd(`ARC_OFF_PREV, ALL, 32'h190);
        rd(`ARC_OFF_ERR, 32'hffff, 32'hff06);
        rd(`ARC_OFF_ISTAT, ALL, 32'h3);
        $display("test double sample done");
        print_verdict();
    end
endmodule : arc_top_bench
`default_nettype wire
